// >>> design/uaf_consts.svh
// Constants for the alternate address filter and transaction status block.
// Assumes a 250 MHz system clock and an 8-bit register port.
`ifndef UAF_CONSTS_SVH
`define UAF_CONSTS_SVH

`define UAF_OFF_STATUS   16'h7F93
`define UAF_OFF_ALT1     16'h7F99
`define UAF_OFF_ALT2     16'h7F9E
`define UAF_OFF_ALT3     16'h7F9F
`define UAF_OFF_IRQ_STAT 16'h7FA0
`define UAF_OFF_IRQ_MASK 16'h7FA1
`define UAF_ALT_RESET    8'h00
`define UAF_EN_BIT       7
`define UAF_ADDR_HI      6
`define UAF_REG_RESET    8'h00
`define UAF_ST_ERR       7
`define UAF_ST_TIMEOUT   6
`define UAF_ST_SETUP     5
`define UAF_ST_SOF       4
`define UAF_ST_PRE       3
`define UAF_ST_ACK       2
`define UAF_ST_BUSRST    1
`define UAF_ST_EOT       0
`define UAF_EP_LO2       4'h8
`define UAF_EP_HI2       4'hB
`define UAF_EP_LO3       4'hC
`define UAF_EP_HI3       4'hF
`define UAF_EP_LO1       4'h0
`define UAF_EP_HI1       4'hF
`define UAF_FLT_ONE      2'h1
`define UAF_FLT_TWO      2'h2
`define UAF_FLT_THREE    2'h3
`define UAF_CLK_MHZ      250
`define UAF_BIT_NS_X10   833
`define UAF_SE0_BITS     32
`define UAF_SE0_CYCLES   ((`UAF_SE0_BITS*`UAF_BIT_NS_X10*`UAF_CLK_MHZ+9999)/10000)
`define UAF_GAP_BITS     16
`define UAF_GAP_CYCLES   ((`UAF_GAP_BITS*`UAF_BIT_NS_X10*`UAF_CLK_MHZ+9999)/10000)
`define UAF_PID_SETUP    4'hD
`define UAF_PID_SOF      4'h5
`define UAF_PID_PRE      4'hC
`define UAF_PID_IN       4'h9
`define UAF_PID_OUT      4'h1
`define UAF_PID_ACK      4'h2

`endif

// >>> design/uaf_pkg.sv
// Types for the alternate address filter and transaction status block.
// Assumes the constants header is included by each user.
package uaf_pkg;

    // Token seen by the serial engine front end
    typedef struct packed {
        logic       valid;
        logic [3:0] pid;
        logic [6:0] addr;
        logic [3:0] ep;
    } uaf_token_type;

    // Endpoint match answer towards the endpoint logic
    typedef struct packed {
        logic       hit;
        logic [1:0] filter;
        logic [3:0] ep;
    } uaf_match_type;

    // Transaction tracker states
    typedef enum logic [1:0] {
        UAF_IDLE = 2'b00,
        UAF_BUSY = 2'b01,
        UAF_DONE = 2'b10
    } uaf_state_type;

endpackage : uaf_pkg

// >>> design/uaf_filter_status.sv
// Alternate address filters, transaction status flags and register port.
// Assumes token and packet events come from engine logic on clk_sys;
// the decoded SE0 line level comes from a pin and is synchronised here.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "uaf_consts.svh"

module uaf_filter_status
    import uaf_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          reset,
    input  wire logic [15:0]   reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output var  logic [7:0]    reg_rdata,
    input  wire uaf_token_type token_in,
    input  wire logic          pkt_start,
    input  wire logic          pkt_error,
    input  wire logic          sync_pre_seen,
    input  wire logic          line_se0,
    output var  uaf_match_type endpoint_match,
    output var  logic          engine_busy,
    output var  logic          irq
);

    // Filter registers; only the enable and address are stored
    logic [7:0]    alt1;
    logic [7:0]    alt2;
    logic [7:0]    alt3;
    logic [7:0]    status;
    logic [7:0]    irq_stat;
    logic [7:0]    irq_mask;
    logic [7:0]    prev_status;
    logic          se0_meta;
    logic          se0_sync;
    logic [9:0]    se0_count;
    logic [8:0]    gap_count;
    uaf_state_type state;
    uaf_state_type next_state;
    logic          txn_end;
    logic          gap_expired;
    uaf_match_type next_match;
    logic          token_open;     // Token PID, not a handshake
    logic [11:0]   se0_seen;       // Checker-only run length of SE0

    // Address compare, enable gating and endpoint range in one place
    function automatic logic filter_hit(input logic [7:0] cfg, input logic [6:0] addr,
                                        input logic [3:0] ep, input logic [3:0] lo,
                                        input logic [3:0] hi);
        filter_hit = cfg[`UAF_EN_BIT] && (cfg[`UAF_ADDR_HI:0] == addr)
                     && (ep >= lo) && (ep <= hi);
    endfunction : filter_hit

    // Register writes; all eight filter bits are read/write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            alt1 <= `UAF_ALT_RESET;
            alt2 <= `UAF_ALT_RESET;
            alt3 <= `UAF_ALT_RESET;
            irq_mask <= `UAF_REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `UAF_OFF_ALT1: alt1 <= reg_wdata;
                `UAF_OFF_ALT2: alt2 <= reg_wdata;
                `UAF_OFF_ALT3: alt3 <= reg_wdata;
                `UAF_OFF_IRQ_MASK: irq_mask <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `UAF_OFF_STATUS:   reg_rdata <= status;
                `UAF_OFF_ALT1:     reg_rdata <= alt1;
                `UAF_OFF_ALT2:     reg_rdata <= alt2;
                `UAF_OFF_ALT3:     reg_rdata <= alt3;
                `UAF_OFF_IRQ_STAT: reg_rdata <= irq_stat;
                `UAF_OFF_IRQ_MASK: reg_rdata <= irq_mask;
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Endpoint match; alternate hits report the inverted endpoint
    always_comb begin
        next_match = '0;
        if (token_in.valid) begin
            // Priority keeps one answer should firmware overlap filters
            if (filter_hit(alt2, token_in.addr, token_in.ep,
                           `UAF_EP_LO2, `UAF_EP_HI2)) begin
                next_match.hit = 1'b1;
                next_match.filter = `UAF_FLT_TWO;
                next_match.ep = ~token_in.ep;
            end else if (filter_hit(alt3, token_in.addr, token_in.ep,
                                    `UAF_EP_LO3, `UAF_EP_HI3)) begin
                next_match.hit = 1'b1;
                next_match.filter = `UAF_FLT_THREE;
                next_match.ep = ~token_in.ep;
            end else if (filter_hit(alt1, token_in.addr, token_in.ep,
                                    `UAF_EP_LO1, `UAF_EP_HI1)) begin
                next_match.hit = 1'b1;
                next_match.filter = `UAF_FLT_ONE;
                next_match.ep = ~token_in.ep;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            endpoint_match <= '0;
        end else begin
            endpoint_match <= next_match;
        end
    end

    // Two-flop synchroniser on the line level
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            se0_meta <= 1'b0;
            se0_sync <= 1'b0;
        end else begin
            se0_meta <= line_se0;
            se0_sync <= se0_meta;
        end
    end

    // SE0 duration counter; saturates at the threshold
    // Ten bits: the threshold lies beyond 511 cycles and must not wrap
    always_ff @(posedge clk_sys) begin
        if (reset || !se0_sync) begin
            se0_count <= 10'h000;
        end else if (se0_count != 10'(`UAF_SE0_CYCLES)) begin
            se0_count <= se0_count + 10'h001;
        end
    end

    // Checker-only SE0 run length, wide enough never to wrap before the limit
    always_ff @(posedge clk_sys) begin
        if (reset || !se0_sync) begin
            se0_seen <= 12'h000;
        end else if (se0_seen != 12'hFFF) begin
            se0_seen <= se0_seen + 12'h001;
        end
    end

    // Inter-packet gap counter, runs only inside a transaction; a token restarts it
    always_ff @(posedge clk_sys) begin
        if (reset || state != UAF_BUSY || pkt_start || token_open) begin
            gap_count <= 9'h000;
        end else if (!gap_expired) begin
            gap_count <= gap_count + 9'h001;
        end
    end
    assign gap_expired = (gap_count == 9'(`UAF_GAP_CYCLES));

    // Transaction tracker: a token opens, handshake, error or gap closes
    always_comb begin
        next_state = state;
        case (state)
            UAF_IDLE: if (token_open) next_state = UAF_BUSY;
            UAF_BUSY: if (txn_end) next_state = UAF_DONE;
            UAF_DONE: if (token_open) next_state = UAF_BUSY;
            default:  next_state = UAF_IDLE;
        endcase
    end
    assign txn_end = pkt_error || gap_expired ||
                     (pkt_start && token_in.pid == `UAF_PID_ACK);
    // A handshake carries a PID too but must close, not reopen, the transaction
    assign token_open = token_in.valid && !pkt_start;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= UAF_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Live status flags; outcome bits settle with the end flag rise
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status <= 8'h00;
        end else begin
            status[`UAF_ST_BUSRST] <= (se0_count == 10'(`UAF_SE0_CYCLES));
            status[`UAF_ST_PRE] <= sync_pre_seen;
            if (token_open) begin
                status[`UAF_ST_EOT]   <= 1'b0;
                status[`UAF_ST_SETUP] <= (token_in.pid == `UAF_PID_SETUP);
                status[`UAF_ST_SOF]   <= (token_in.pid == `UAF_PID_SOF);
                status[`UAF_ST_ERR]     <= 1'b0;
                status[`UAF_ST_TIMEOUT] <= 1'b0;
                status[`UAF_ST_ACK]     <= 1'b0;
            end else if (state == UAF_BUSY && txn_end) begin
                status[`UAF_ST_EOT]     <= 1'b1;
                status[`UAF_ST_ERR]     <= pkt_error;
                status[`UAF_ST_TIMEOUT] <= gap_expired && !pkt_error;
                status[`UAF_ST_ACK]     <= !pkt_error && !gap_expired;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            engine_busy <= 1'b0;
        end else begin
            engine_busy <= (next_state == UAF_BUSY);
        end
    end

    // Interrupt: rising status bits are sticky; set wins over clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prev_status <= 8'h00;
            irq_stat <= 8'h00;
            irq <= 1'b0;
        end else begin
            prev_status <= status;
            irq_stat <= (irq_stat & ~((reg_wr && reg_addr == `UAF_OFF_IRQ_STAT) ?
                         reg_wdata : 8'h00)) | (status & ~prev_status);
            irq <= |(irq_stat & irq_mask);
        end
    end

    // Outcome flags are never both acknowledge and error
    chk_ack_excl: assert property (@(posedge clk_sys) disable iff (reset)
        !(status[`UAF_ST_ACK] && status[`UAF_ST_ERR]))
        else $error("ack and error set together");

    chk_alt_invert: assert property (@(posedge clk_sys) disable iff (reset)
        next_match.hit |=> endpoint_match.ep == ~$past(token_in.ep))
        else $error("endpoint not inverted");

    chk_disabled_none: assert property (@(posedge clk_sys) disable iff (reset)
        (!alt1[`UAF_EN_BIT] && !alt2[`UAF_EN_BIT] && !alt3[`UAF_EN_BIT]) |-> !next_match.hit)
        else $error("disabled filter matched");

    chk_range_two: assert property (@(posedge clk_sys) disable iff (reset)
        (next_match.filter == `UAF_FLT_TWO) |-> token_in.ep[3:2] == 2'b10)
        else $error("filter two out of range");

    chk_range_three: assert property (@(posedge clk_sys) disable iff (reset)
        (next_match.filter == `UAF_FLT_THREE) |-> token_in.ep[3:2] == 2'b11)
        else $error("filter three out of range");

    sequence s_txn_open;
        token_open;
    endsequence
    sequence s_txn_close;
        state == UAF_BUSY && txn_end && !token_open;
    endsequence
    chk_eot_fall: assert property (@(posedge clk_sys) disable iff (reset)
        s_txn_open |=> !status[`UAF_ST_EOT])
        else $error("end flag not cleared");

    chk_eot_rise: assert property (@(posedge clk_sys) disable iff (reset)
        s_txn_close |=> status[`UAF_ST_EOT])
        else $error("end flag not set");

    chk_setup_flag: assert property (@(posedge clk_sys) disable iff (reset)
        (token_open && token_in.pid == `UAF_PID_SETUP) |=> status[`UAF_ST_SETUP])
        else $error("setup flag missing");

    chk_busrst_time: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(status[`UAF_ST_BUSRST]) |-> se0_count == 10'(`UAF_SE0_CYCLES))
        else $error("bus reset too early");

    chk_pre_flag: assert property (@(posedge clk_sys) disable iff (reset)
        sync_pre_seen |=> status[`UAF_ST_PRE])
        else $error("preamble flag missing");

    chk_pre_drop: assert property (@(posedge clk_sys) disable iff (reset)
        !sync_pre_seen |=> !status[`UAF_ST_PRE])
        else $error("preamble flag stuck");

    // Each hit names the filter whose enable and address agree
    chk_addr_two: assert property (@(posedge clk_sys) disable iff (reset)
        (next_match.filter == `UAF_FLT_TWO) |->
        (alt2[`UAF_EN_BIT] && alt2[`UAF_ADDR_HI:0] == token_in.addr))
        else $error("filter two address mismatch");

    chk_addr_three: assert property (@(posedge clk_sys) disable iff (reset)
        (next_match.filter == `UAF_FLT_THREE) |->
        (alt3[`UAF_EN_BIT] && alt3[`UAF_ADDR_HI:0] == token_in.addr))
        else $error("filter three address mismatch");

    chk_addr_one: assert property (@(posedge clk_sys) disable iff (reset)
        (next_match.filter == `UAF_FLT_ONE) |->
        (alt1[`UAF_EN_BIT] && alt1[`UAF_ADDR_HI:0] == token_in.addr))
        else $error("filter one address mismatch");

    // No token, no answer in the following cycle
    chk_match_quiet: assert property (@(posedge clk_sys) disable iff (reset)
        !token_in.valid |=> !endpoint_match.hit)
        else $error("match without token");

    // Filter writes land in the next cycle, all eight bits
    chk_alt2_write: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr == `UAF_OFF_ALT2) |=> alt2 == $past(reg_wdata))
        else $error("filter two write lost");

    chk_alt3_write: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr == `UAF_OFF_ALT3) |=> alt3 == $past(reg_wdata))
        else $error("filter three write lost");

    // Outcome flags follow the cause of the close
    chk_timeout_excl: assert property (@(posedge clk_sys) disable iff (reset)
        !(status[`UAF_ST_TIMEOUT] && status[`UAF_ST_ACK]))
        else $error("ack and timeout set together");

    chk_err_end: assert property (@(posedge clk_sys) disable iff (reset)
        (state == UAF_BUSY && pkt_error && !token_open) |=>
        (status[`UAF_ST_ERR] && status[`UAF_ST_EOT]))
        else $error("error flag missing");

    sequence s_gap_close;
        state == UAF_BUSY && gap_expired && !pkt_error && !token_open;
    endsequence
    chk_gap_close: assert property (@(posedge clk_sys) disable iff (reset)
        s_gap_close |=> (status[`UAF_ST_TIMEOUT] && !status[`UAF_ST_ACK]))
        else $error("timeout flag missing");

    sequence s_ack_close;
        state == UAF_BUSY && pkt_start && token_in.pid == `UAF_PID_ACK &&
            !pkt_error && !gap_expired;
    endsequence
    chk_ack_close: assert property (@(posedge clk_sys) disable iff (reset)
        s_ack_close |=> (status[`UAF_ST_ACK] && status[`UAF_ST_EOT]))
        else $error("acknowledge flag missing");

    chk_sof_flag: assert property (@(posedge clk_sys) disable iff (reset)
        (token_open && token_in.pid == `UAF_PID_SOF) |=> status[`UAF_ST_SOF])
        else $error("frame start flag missing");

    // Bus reset against an independent, wider run counter
    sequence s_se0_gone;
        !se0_sync ##1 !se0_sync;
    endsequence
    chk_busrst_drop: assert property (@(posedge clk_sys) disable iff (reset)
        s_se0_gone |=> !status[`UAF_ST_BUSRST])
        else $error("bus reset flag stuck");

    chk_busrst_min: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(status[`UAF_ST_BUSRST]) |-> $past(se0_seen) >= 12'(`UAF_SE0_CYCLES))
        else $error("bus reset before threshold");

    chk_busrst_late: assert property (@(posedge clk_sys) disable iff (reset)
        (se0_seen == 12'(`UAF_SE0_CYCLES + 1)) |-> status[`UAF_ST_BUSRST])
        else $error("bus reset not raised");

    // Busy output opens with a token and drops at the close
    chk_busy_open: assert property (@(posedge clk_sys) disable iff (reset)
        (token_open && state != UAF_BUSY) |=> engine_busy)
        else $error("busy not raised");

    chk_busy_close: assert property (@(posedge clk_sys) disable iff (reset)
        s_txn_close |=> !engine_busy)
        else $error("busy not dropped");

    // Interrupt level and sticky capture; a rise beats a same-cycle clear
    chk_irq_level: assert property (@(posedge clk_sys) disable iff (reset)
        irq == $past(|(irq_stat & irq_mask)))
        else $error("interrupt level wrong");

    chk_irq_set: assert property (@(posedge clk_sys) disable iff (reset)
        (|(status & ~prev_status)) |=>
        ((irq_stat & $past(status & ~prev_status)) == $past(status & ~prev_status)))
        else $error("status rise not captured");

endmodule : uaf_filter_status

`default_nettype wire

// >>> testbench/uaf_host_model.sv
// Host side model: drives token, packet and line events of the bus.
// Assumes the bench calls its tasks from one process, after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module uaf_host_model
    import uaf_pkg::*;
(
    input  wire logic          clk_sys,
    output var  uaf_token_type token_in,
    output var  logic          pkt_start,
    output var  logic          pkt_error,
    output var  logic          sync_pre_seen,
    output var  logic          line_se0
);
    // Quiet bus at time zero
    initial begin
        token_in = '0;
        pkt_start = 1'b0;
        pkt_error = 1'b0;
        sync_pre_seen = 1'b0;
        line_se0 = 1'b0;
    end

    // One PID for one cycle; fields inverted after, so stale values never match
    task automatic send_pid(input logic [3:0] pid, input logic [6:0] addr,
                            input logic [3:0] ep, input logic hs);
        @(posedge clk_sys);
        token_in <= {1'b1, pid, addr, ep};
        pkt_start <= hs;
        @(posedge clk_sys);
        token_in <= {1'b0, ~pid, ~addr, ~ep};
        pkt_start <= 1'b0;
    endtask : send_pid

    // Corrupt packet inside the open transaction
    task automatic send_error();
        @(posedge clk_sys);
        pkt_error <= 1'b1;
        @(posedge clk_sys);
        pkt_error <= 1'b0;
    endtask : send_error

    // Line levels: preamble seen, single-ended zero
    task automatic set_lines(input logic pre, input logic se0);
        @(posedge clk_sys);
        sync_pre_seen <= pre;
        line_se0 <= se0;
    endtask : set_lines
endmodule : uaf_host_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the filter and status block.
// Assumes the host model drives every bus-side input of the design.
`timescale 1ns/10ps
`default_nettype none
`include "uaf_consts.svh"
module tb_top
    import uaf_pkg::*;
;
    typedef struct packed {
        logic [7:0] val;
        logic [7:0] msk;
    } uaf_exp_type;
    logic          clk_sys = 1'b0;
    logic          reset = 1'b1;
    logic [15:0]   reg_addr = '0;
    logic [7:0]    reg_wdata = '0;
    logic          reg_wr = 1'b0;
    logic          reg_rd = 1'b0;
    logic [7:0]    reg_rdata, v;
    uaf_token_type token_in;
    logic          pkt_start, pkt_error, sync_pre_seen, line_se0;
    uaf_match_type endpoint_match;
    logic          engine_busy, irq;
    logic          rd_seen = 1'b0;
    logic          tok_seen = 1'b0;
    uaf_exp_type   rq[$], mq[$];
    int            num_errors = 0, comparisons = 0, seed = 7;
    logic [3:0]    pids[4] = '{`UAF_PID_SETUP, `UAF_PID_SOF, `UAF_PID_IN, `UAF_PID_OUT};

    always #2 clk_sys = ~clk_sys;

    uaf_filter_status u_uaf_filter_status (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .token_in(token_in), .pkt_start(pkt_start),
        .pkt_error(pkt_error), .sync_pre_seen(sync_pre_seen), .line_se0(line_se0),
        .endpoint_match(endpoint_match), .engine_busy(engine_busy), .irq(irq));
    uaf_host_model u_uaf_host_model (
        .clk_sys(clk_sys), .token_in(token_in), .pkt_start(pkt_start),
        .pkt_error(pkt_error), .sync_pre_seen(sync_pre_seen), .line_se0(line_se0));

    task automatic cmp(input logic [7:0] got, input uaf_exp_type e, input string what);
        comparisons++;
        if (((got ^ e.val) & e.msk) !== 8'h00) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, e.val);
        end
    endtask : cmp
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
        rq.push_back('{e, m});
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : rd
    // Filter f of zero means no filter may claim the token
    task automatic tok(input logic [3:0] pid, input logic [6:0] a, input logic [3:0] ep,
                       input logic hs, input logic [1:0] f);
        mq.push_back('{{1'b0, f != 2'd0, f, ~ep}, (f != 2'd0) ? 8'h7F : 8'h40});
        u_uaf_host_model.send_pid(pid, a, ep, hs);
    endtask : tok
    // Sampled mid-cycle, clear of the edge that updates it
    task automatic chk_irq(input logic e);
        @(negedge clk_sys);
        cmp({7'h00, irq}, '{{7'h00, e}, 8'hFF}, "irq");
    endtask : chk_irq
    task automatic chk_busy(input logic e);
        @(negedge clk_sys);
        cmp({7'h00, engine_busy}, '{{7'h00, e}, 8'hFF}, "busy");
    endtask : chk_busy
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // Watcher: answers stand the cycle after their request
    always @(posedge clk_sys) begin
        if (rd_seen) cmp(reg_rdata, rq.pop_front(), "read");
        if (tok_seen) cmp({1'b0, endpoint_match}, mq.pop_front(), "match");
        rd_seen <= reg_rd;
        tok_seen <= token_in.valid;
    end

    // Stimulus needs about 1400 cycles; this cuts a hang well after
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        rd(`UAF_OFF_ALT2, 8'h00, 8'hFF);
        rd(`UAF_OFF_ALT3, 8'h00, 8'hFF);
        wr(`UAF_OFF_STATUS, 8'hFF);
        rd(`UAF_OFF_STATUS, 8'h00, 8'hFF);
        wr(16'h7F00, 8'hA5);
        rd(16'h7F00, 8'h00, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            wr(i[0] ? `UAF_OFF_ALT3 : `UAF_OFF_ALT2, v);
            rd(i[0] ? `UAF_OFF_ALT3 : `UAF_OFF_ALT2, v, 8'hFF);
        end
        // Disjoint filters at 12 and 34; the one at 56 is left disabled
        wr(`UAF_OFF_ALT2, 8'h92);
        wr(`UAF_OFF_ALT3, 8'hB4);
        wr(`UAF_OFF_ALT1, 8'h56);
        for (int e = 0; e < 16; e++) begin
            tok(`UAF_PID_IN, 7'h12, e[3:0], 1'b0, (e > 7 && e < 12) ? 2'd2 : 2'd0);
            tok(`UAF_PID_OUT, 7'h34, e[3:0], 1'b0, (e > 11) ? 2'd3 : 2'd0);
            tok(`UAF_PID_IN, 7'h56, e[3:0], 1'b0, 2'd0);
        end
        wr(`UAF_OFF_ALT1, 8'hD6);
        wr(`UAF_OFF_ALT2, 8'h12);
        for (int e = 0; e < 16; e++) begin
            tok(`UAF_PID_IN, 7'h56, e[3:0], 1'b0, 2'd1);
            tok(`UAF_PID_IN, 7'h12, e[3:0], 1'b0, 2'd0);
        end
        tok(`UAF_PID_OUT, 7'h57, 4'h9, 1'b0, 2'd0);
        // Each token kind, closed by ACK, error, timeout and ACK in turn
        for (int k = 0; k < 4; k++) begin
            tok(pids[k], 7'h7F, 4'h0, 1'b0, 2'd0);
            chk_busy(1'b1);
            rd(`UAF_OFF_STATUS, {2'b00, k == 0, k == 1, 4'h0}, 8'hF5);
            case (k)
                1: u_uaf_host_model.send_error();
                2: idle(400);
                default: tok(`UAF_PID_ACK, 7'h7F, 4'h0, 1'b1, 2'd0);
            endcase
            idle(2);
            rd(`UAF_OFF_STATUS, {k == 1, k == 2, 3'b000, k == 0 || k == 3, 2'b01},
               8'hC5);
            chk_busy(1'b0);
        end
        u_uaf_host_model.set_lines(1'b1, 1'b0);
        idle(4);
        rd(`UAF_OFF_STATUS, 8'h08, 8'h08);
        u_uaf_host_model.set_lines(1'b0, 1'b1);
        idle(600);
        rd(`UAF_OFF_STATUS, 8'h00, 8'h0A);
        idle(100);
        rd(`UAF_OFF_STATUS, 8'h02, 8'h02);
        u_uaf_host_model.set_lines(1'b0, 1'b0);
        idle(6);
        rd(`UAF_OFF_STATUS, 8'h00, 8'h02);
        // Every status bit has risen once; mask still closed
        rd(`UAF_OFF_IRQ_STAT, 8'hFF, 8'hFF);
        chk_irq(1'b0);
        wr(`UAF_OFF_IRQ_MASK, 8'h02);
        idle(2);
        chk_irq(1'b1);
        wr(`UAF_OFF_IRQ_STAT, 8'h02);
        rd(`UAF_OFF_IRQ_STAT, 8'hFD, 8'hFF);
        chk_irq(1'b0);
        wr(`UAF_OFF_IRQ_STAT, 8'hFF);
        wr(`UAF_OFF_IRQ_MASK, 8'h01);
        tok(`UAF_PID_IN, 7'h7F, 4'h0, 1'b0, 2'd0);
        u_uaf_host_model.send_error();
        idle(3);
        chk_irq(1'b1);
        wr(`UAF_OFF_IRQ_MASK, 8'h00);
        idle(2);
        chk_irq(1'b0);
        idle(4);
        cmp(8'(rq.size() + mq.size()), '{8'h00, 8'hFF}, "pending");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
